// ### rtl/ddc_pkg.sv
// constants and types for the command spacing controller
package ddc_pkg;
   // command clock period in picoseconds
   localparam int CLK_PS = 20000;
   localparam int TW     = 6;
   localparam int BG_W   = 2;
   localparam int BA_W   = 2;
   localparam int NUM_BG = 4;
   localparam int NUM_BK = 16;
   localparam int FAW_SLOTS = 4;

   typedef enum logic [2:0] {
      CMD_NOP = 3'h0,
      CMD_ACT = 3'h1,
      CMD_RD  = 3'h3,
      CMD_WR  = 3'h2,
      CMD_PRE = 3'h6,
      CMD_MRS = 3'h7
   } ddc_cmd_type;

   localparam logic [1:0] PAGE_HALF = 2'h0;
   localparam logic [1:0] PAGE_1K   = 2'h1;
   localparam logic [1:0] PAGE_2K   = 2'h2;

   // larger of a cycle count and a time rounded up to whole cycles
   function automatic int ddc_cyc(input int nck, input int ps);
      int t;
      t = (ps + CLK_PS - 1) / CLK_PS;
      return (t > nck) ? t : nck;
   endfunction

   localparam int COLUMN_GAP_SAME_GROUP_NCK    = 4;
   localparam int COLUMN_GAP_SAME_GROUP_PS     = 5355;
   localparam int COLUMN_GAP_OTHER_GROUP_NCK   = 4;
   localparam int ACT_GAP_OTHER_2K_PS          = 5300;
   localparam int ACT_GAP_OTHER_1K_PS          = 3700;
   localparam int ACT_GAP_SAME_2K_PS           = 6400;
   localparam int ACT_GAP_SAME_1K_PS           = 5300;
   localparam int ACT_GAP_NCK                  = 4;
   localparam int FAW_2K_NCK = 28;
   localparam int FAW_2K_PS  = 30000;
   localparam int FAW_1K_NCK = 20;
   localparam int FAW_1K_PS  = 21000;
   localparam int FAW_HK_NCK = 16;
   localparam int FAW_HK_PS  = 15000;
   localparam int WTR_OTHER_NCK = 2;
   localparam int WTR_OTHER_PS  = 2500;
   localparam int WTR_SAME_NCK  = 4;
   localparam int WTR_SAME_PS   = 7500;
   localparam int CRC_MASK_NCK  = 5;
   localparam int CRC_MASK_PS   = 3750;
   localparam int RTP_NCK       = 4;
   localparam int RTP_PS        = 7500;
   localparam int WR_REC_PS     = 15000;
   localparam int MODE_SET_NCK  = 8;

   localparam int CCD_L_CYC    = ddc_cyc(COLUMN_GAP_SAME_GROUP_NCK,
                                         COLUMN_GAP_SAME_GROUP_PS);
   localparam int CCD_S_CYC    = COLUMN_GAP_OTHER_GROUP_NCK;
   localparam int RRD_S_2K_CYC = ddc_cyc(ACT_GAP_NCK, ACT_GAP_OTHER_2K_PS);
   localparam int RRD_S_1K_CYC = ddc_cyc(ACT_GAP_NCK, ACT_GAP_OTHER_1K_PS);
   localparam int RRD_L_2K_CYC = ddc_cyc(ACT_GAP_NCK, ACT_GAP_SAME_2K_PS);
   localparam int RRD_L_1K_CYC = ddc_cyc(ACT_GAP_NCK, ACT_GAP_SAME_1K_PS);
   localparam int FAW_2K_CYC   = ddc_cyc(FAW_2K_NCK, FAW_2K_PS);
   localparam int FAW_1K_CYC   = ddc_cyc(FAW_1K_NCK, FAW_1K_PS);
   localparam int FAW_HK_CYC   = ddc_cyc(FAW_HK_NCK, FAW_HK_PS);
   localparam int WTR_S_CYC    = ddc_cyc(WTR_OTHER_NCK, WTR_OTHER_PS);
   localparam int WTR_L_CYC    = ddc_cyc(WTR_SAME_NCK, WTR_SAME_PS);
   localparam int CRC_DM_CYC   = ddc_cyc(CRC_MASK_NCK, CRC_MASK_PS);
   localparam int RTP_CYC      = ddc_cyc(RTP_NCK, RTP_PS);
   localparam int WR_REC_CYC   = ddc_cyc(1, WR_REC_PS);
   localparam int MRD_CYC      = MODE_SET_NCK;
endpackage

// ### rtl/ddc_gap_timer.sv
// down counter that stays busy until a loaded gap has elapsed
`timescale 1ns/10ps
`default_nettype none
module ddc_gap_timer #(
   parameter int W = 6
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // gap load
   input  wire logic         load,
   input  wire logic [W-1:0] value,
   // state
   output logic              busy
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;

   // a new gap never shortens one already running
   always_comb begin
      cnt_nxt = cnt_r;
      if (cnt_r != {W{1'b0}}) begin
         cnt_nxt = cnt_r - 1'b1;
      end
      if (load && (value > cnt_nxt)) begin
         cnt_nxt = value;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_r <= {W{1'b0}};
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign busy = (cnt_r != {W{1'b0}});
endmodule
`default_nettype wire

// ### rtl/ddc_cmd_spacer.sv
// command issuer that holds each request until all spacing gaps have run
`timescale 1ns/10ps
`default_nettype none
module ddc_cmd_spacer
   import ddc_pkg::*;
#(
   // cycles from a write command to the start of its internal write
   parameter int WRITE_START_CYC = 0
) (
   // clock and reset
   input  wire logic            CORE_CLK,
   input  wire logic            RST_N,
   // configuration
   input  wire logic [1:0]      PAGE_SIZE,
   input  wire logic            CRC_DM_EN,
   // command request
   input  wire logic            REQ_VALID,
   input  wire logic [2:0]      REQ_CMD,
   input  wire logic [BG_W-1:0] REQ_BG,
   input  wire logic [BA_W-1:0] REQ_BA,
   output logic                 REQ_ACK,
   // command to the memory
   output logic                 CMD_VALID,
   output logic [2:0]           CMD_CODE,
   output logic [BG_W-1:0]      CMD_BG,
   output logic [BA_W-1:0]      CMD_BA
);
   localparam int FP_W = $clog2(FAW_SLOTS);

   logic                 ack_r;
   logic                 ack_nxt;
   logic                 cvalid_r;
   logic                 cvalid_nxt;
   logic [2:0]           ccode_r;
   logic [2:0]           ccode_nxt;
   logic [BG_W-1:0]      cbg_r;
   logic [BG_W-1:0]      cbg_nxt;
   logic [BA_W-1:0]      cba_r;
   logic [BA_W-1:0]      cba_nxt;
   logic [FP_W-1:0]      fptr_r;
   logic [FP_W-1:0]      fptr_nxt;

   logic                 ok;
   logic                 accept;
   logic [3:0]           bank;
   logic                 is_act;
   logic                 is_rd;
   logic                 is_wr;
   logic                 is_col;

   logic                 ccd_s_busy;
   logic                 rrd_s_busy;
   logic                 wtr_s_busy;
   logic                 mrd_busy;
   logic [NUM_BG-1:0]    ccd_l_busy;
   logic [NUM_BG-1:0]    rrd_l_busy;
   logic [NUM_BG-1:0]    wtr_l_busy;
   logic [NUM_BK-1:0]    pre_busy;
   logic [FAW_SLOTS-1:0] faw_busy;

   logic [TW-1:0]        rrd_s_val;
   logic [TW-1:0]        rrd_l_val;
   logic [TW-1:0]        faw_val;
   logic [TW-1:0]        wtr_s_val;
   logic [TW-1:0]        wtr_l_val;
   logic [TW-1:0]        wrec_val;
   logic [TW-1:0]        crc_add;

   // timers hold cycles-1 because the command leaves one cycle after accept
   localparam logic [TW-1:0] CCD_L_V    = TW'(CCD_L_CYC - 1);
   localparam logic [TW-1:0] CCD_S_V    = TW'(CCD_S_CYC - 1);
   localparam logic [TW-1:0] RRD_S_2K_V = TW'(RRD_S_2K_CYC - 1);
   localparam logic [TW-1:0] RRD_S_1K_V = TW'(RRD_S_1K_CYC - 1);
   localparam logic [TW-1:0] RRD_L_2K_V = TW'(RRD_L_2K_CYC - 1);
   localparam logic [TW-1:0] RRD_L_1K_V = TW'(RRD_L_1K_CYC - 1);
   localparam logic [TW-1:0] FAW_2K_V   = TW'(FAW_2K_CYC - 1);
   localparam logic [TW-1:0] FAW_1K_V   = TW'(FAW_1K_CYC - 1);
   localparam logic [TW-1:0] FAW_HK_V   = TW'(FAW_HK_CYC - 1);
   localparam logic [TW-1:0] WTR_S_V    = TW'(WTR_S_CYC + WRITE_START_CYC - 1);
   localparam logic [TW-1:0] WTR_L_V    = TW'(WTR_L_CYC + WRITE_START_CYC - 1);
   localparam logic [TW-1:0] CRC_DM_V   = TW'(CRC_DM_CYC);
   localparam logic [TW-1:0] RTP_V      = TW'(RTP_CYC - 1);
   localparam logic [TW-1:0] WR_REC_V   = TW'(WR_REC_CYC + WRITE_START_CYC - 1);
   localparam logic [TW-1:0] MRD_V      = TW'(MRD_CYC - 1);
   localparam logic [TW-1:0] ZERO_V     = TW'(0);

   assign bank   = {REQ_BG, REQ_BA};
   assign is_act = (REQ_CMD == CMD_ACT);
   assign is_rd  = (REQ_CMD == CMD_RD);
   assign is_wr  = (REQ_CMD == CMD_WR);
   assign is_col = is_rd | is_wr;

   // gap values picked by page size and the CRC plus mask mode
   always_comb begin
      crc_add   = CRC_DM_EN ? CRC_DM_V : ZERO_V;
      wtr_s_val = WTR_S_V + crc_add;
      wtr_l_val = WTR_L_V + crc_add;
      wrec_val  = WR_REC_V + crc_add;
      if (PAGE_SIZE == PAGE_2K) begin
         rrd_s_val = RRD_S_2K_V;
         rrd_l_val = RRD_L_2K_V;
         faw_val   = FAW_2K_V;
      end else if (PAGE_SIZE == PAGE_1K) begin
         rrd_s_val = RRD_S_1K_V;
         rrd_l_val = RRD_L_1K_V;
         faw_val   = FAW_1K_V;
      end else begin
         rrd_s_val = RRD_S_1K_V;
         rrd_l_val = RRD_L_1K_V;
         faw_val   = FAW_HK_V;
      end
   end

   // spacing check for the pending request
   always_comb begin
      case (REQ_CMD)
         CMD_ACT: ok = !rrd_s_busy && !rrd_l_busy[REQ_BG]
                       && !faw_busy[fptr_r];
         CMD_RD:  ok = !ccd_s_busy && !ccd_l_busy[REQ_BG]
                       && !wtr_s_busy && !wtr_l_busy[REQ_BG];
         CMD_WR:  ok = !ccd_s_busy && !ccd_l_busy[REQ_BG];
         CMD_PRE: ok = !pre_busy[bank];
         CMD_MRS: ok = !mrd_busy;
         default: ok = 1'b1;
      endcase
   end

   // the cycle after an accept is skipped so a held request is not reissued
   assign accept = REQ_VALID && ok && !ack_r;

   // device-wide timers
   ddc_gap_timer #(.W(TW)) u_ccd_s (
      .clk   (CORE_CLK),
      .rst_n (RST_N),
      .load  (accept && is_col),
      .value (CCD_S_V),
      .busy  (ccd_s_busy)
   );

   ddc_gap_timer #(.W(TW)) u_rrd_s (
      .clk   (CORE_CLK),
      .rst_n (RST_N),
      .load  (accept && is_act),
      .value (rrd_s_val),
      .busy  (rrd_s_busy)
   );

   ddc_gap_timer #(.W(TW)) u_wtr_s (
      .clk   (CORE_CLK),
      .rst_n (RST_N),
      .load  (accept && is_wr),
      .value (wtr_s_val),
      .busy  (wtr_s_busy)
   );

   ddc_gap_timer #(.W(TW)) u_mrd (
      .clk   (CORE_CLK),
      .rst_n (RST_N),
      .load  (accept && (REQ_CMD == CMD_MRS)),
      .value (MRD_V),
      .busy  (mrd_busy)
   );

   // per bank group timers
   genvar g;
   generate
      for (g = 0; g < NUM_BG; g++) begin : g_grp
         logic hit;
         assign hit = accept && (REQ_BG == BG_W'(g));

         ddc_gap_timer #(.W(TW)) u_ccd_l (
            .clk   (CORE_CLK),
            .rst_n (RST_N),
            .load  (hit && is_col),
            .value (CCD_L_V),
            .busy  (ccd_l_busy[g])
         );

         ddc_gap_timer #(.W(TW)) u_rrd_l (
            .clk   (CORE_CLK),
            .rst_n (RST_N),
            .load  (hit && is_act),
            .value (rrd_l_val),
            .busy  (rrd_l_busy[g])
         );

         ddc_gap_timer #(.W(TW)) u_wtr_l (
            .clk   (CORE_CLK),
            .rst_n (RST_N),
            .load  (hit && is_wr),
            .value (wtr_l_val),
            .busy  (wtr_l_busy[g])
         );
      end
   endgenerate

   // per bank precharge hold-off: the longer of read and write gaps wins
   genvar b;
   generate
      for (b = 0; b < NUM_BK; b++) begin : g_bank
         logic hit;
         assign hit = accept && (bank == 4'(b));

         ddc_gap_timer #(.W(TW)) u_pre (
            .clk   (CORE_CLK),
            .rst_n (RST_N),
            .load  (hit && is_col),
            .value (is_wr ? wrec_val : RTP_V),
            .busy  (pre_busy[b])
         );
      end
   endgenerate

   // rolling window: the slot to reuse holds the fourth-last activate
   genvar f;
   generate
      for (f = 0; f < FAW_SLOTS; f++) begin : g_faw
         ddc_gap_timer #(.W(TW)) u_faw (
            .clk   (CORE_CLK),
            .rst_n (RST_N),
            .load  (accept && is_act && (fptr_r == FP_W'(f))),
            .value (faw_val),
            .busy  (faw_busy[f])
         );
      end
   endgenerate

   always_comb begin
      ack_nxt    = accept;
      cvalid_nxt = accept;
      ccode_nxt  = accept ? REQ_CMD : CMD_NOP;
      cbg_nxt    = accept ? REQ_BG : cbg_r;
      cba_nxt    = accept ? REQ_BA : cba_r;
      fptr_nxt   = fptr_r;
      if (accept && is_act) begin
         fptr_nxt = fptr_r + 1'b1;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         ack_r    <= 1'b0;
         cvalid_r <= 1'b0;
         ccode_r  <= CMD_NOP;
         cbg_r    <= {BG_W{1'b0}};
         cba_r    <= {BA_W{1'b0}};
         fptr_r   <= {FP_W{1'b0}};
      end else begin
         ack_r    <= ack_nxt;
         cvalid_r <= cvalid_nxt;
         ccode_r  <= ccode_nxt;
         cbg_r    <= cbg_nxt;
         cba_r    <= cba_nxt;
         fptr_r   <= fptr_nxt;
      end
   end

   assign REQ_ACK   = ack_r;
   assign CMD_VALID = cvalid_r;
   assign CMD_CODE  = ccode_r;
   assign CMD_BG    = cbg_r;
   assign CMD_BA    = cba_r;
endmodule
`default_nettype wire

// ### bench/ddc_cmd_spacer_properties.sv
// spacing and handshake assertions for the command spacing controller
`timescale 1ns/10ps
`default_nettype none
module ddc_cmd_spacer_properties
   import ddc_pkg::*;
#(
   parameter int WRITE_START_CYC = 0
) (
   // clock and reset
   input  wire logic            CORE_CLK,
   input  wire logic            RST_N,
   // configuration
   input  wire logic [1:0]      PAGE_SIZE,
   input  wire logic            CRC_DM_EN,
   // command request
   input  wire logic            REQ_VALID,
   input  wire logic [2:0]      REQ_CMD,
   input  wire logic [BG_W-1:0] REQ_BG,
   input  wire logic [BA_W-1:0] REQ_BA,
   input  wire logic            REQ_ACK,
   // command to the memory
   input  wire logic            CMD_VALID,
   input  wire logic [2:0]      CMD_CODE,
   input  wire logic [BG_W-1:0] CMD_BG,
   input  wire logic [BA_W-1:0] CMD_BA
);
   // ages saturate high so nothing looks recent right after reset
   logic [6:0]      col_r, col_nxt;
   logic [6:0]      act_r, act_nxt;
   logic [6:0]      wr_r, wr_nxt;
   logic [6:0]      mrs_r, mrs_nxt;
   logic [BG_W-1:0] wbg_r, wbg_nxt;
   logic [6:0]      wtr_need;
   logic            is_rd, is_wr, is_act, is_mrs;

   assign is_rd  = CMD_VALID && CMD_CODE == CMD_RD;
   assign is_wr  = CMD_VALID && CMD_CODE == CMD_WR;
   assign is_act = CMD_VALID && CMD_CODE == CMD_ACT;
   assign is_mrs = CMD_VALID && CMD_CODE == CMD_MRS;
   assign wtr_need = ((CMD_BG == wbg_r) ? 7'h04 : 7'h02) +
                     (CRC_DM_EN ? 7'h05 : 7'h00) + 7'(WRITE_START_CYC);

   function automatic logic [6:0] age(input logic [6:0] v, input logic hit);
      return hit ? 7'h01 : ((v == 7'h7F) ? v : v + 7'h01);
   endfunction

   always_comb begin
      col_nxt = age(col_r, is_rd || is_wr);
      act_nxt = age(act_r, is_act);
      wr_nxt  = age(wr_r, is_wr);
      mrs_nxt = age(mrs_r, is_mrs);
      wbg_nxt = is_wr ? CMD_BG : wbg_r;
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         col_r <= 7'h7F;
         act_r <= 7'h7F;
         wr_r  <= 7'h7F;
         mrs_r <= 7'h7F;
         wbg_r <= '0;
      end else begin
         col_r <= col_nxt;
         act_r <= act_nxt;
         wr_r  <= wr_nxt;
         mrs_r <= mrs_nxt;
         wbg_r <= wbg_nxt;
      end
   end

   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);

   a_col_gap: assert property (is_rd || is_wr |-> col_r >= 7'h04)
      else $error("column commands closer than four cycles");
   a_act_gap: assert property (is_act |-> act_r >= 7'h04)
      else $error("activates closer than four cycles");
   a_wtr_gap: assert property (is_rd |-> wr_r >= wtr_need)
      else $error("read too soon after write");
   a_mrs_gap: assert property (is_mrs |-> mrs_r >= 7'h08)
      else $error("mode sets closer than eight cycles");
   a_ack_with_cmd: assert property (REQ_ACK == CMD_VALID)
      else $error("ack and command pulse apart");
   a_ack_cause: assert property (REQ_ACK |-> $past(REQ_VALID) &&
      CMD_CODE == $past(REQ_CMD) && CMD_BG == $past(REQ_BG))
      else $error("issued command differs from request");
   a_issue_skip: assert property (CMD_VALID |=> !CMD_VALID)
      else $error("commands on adjacent cycles");
   a_code_idle: assert property (!CMD_VALID |-> CMD_CODE == 3'h0)
      else $error("code not idle between commands");
   a_addr_hold: assert property (!CMD_VALID |-> $stable(CMD_BG) &&
      $stable(CMD_BA))
      else $error("address moved between commands");
endmodule
`default_nettype wire

// ### bench/ddc_mem_model.sv
// memory device model that counts command spacing faults
`timescale 1ns/10ps
`default_nettype none
module ddc_mem_model
   import ddc_pkg::*;
(
   // clock and reset
   input  wire logic            clk,
   input  wire logic            rst_n,
   // configuration
   input  wire logic [1:0]      page_size,
   input  wire logic            crc_dm_en,
   // issued command
   input  wire logic            cmd_valid,
   input  wire logic [2:0]      cmd_code,
   input  wire logic [BG_W-1:0] cmd_bg,
   input  wire logic [BA_W-1:0] cmd_ba,
   // spacing faults seen
   output var int               viol
);
   // ns minima round to two cycles or less at 20 ns, so cycle counts rule
   int t, c, fw, fp, k, l_mrs;
   int l_col[NUM_BG], l_act[NUM_BG], l_wr[NUM_BG];
   int l_rd[NUM_BK], l_wb[NUM_BK], faw[FAW_SLOTS];

   always @(posedge clk) begin
      if (!rst_n) begin
         t = 0;
         viol = 0;
         fp = 0;
         l_mrs = -99;
         foreach (l_col[i]) l_col[i] = -99;
         foreach (l_act[i]) l_act[i] = -99;
         foreach (l_wr[i]) l_wr[i] = -99;
         foreach (l_rd[i]) l_rd[i] = -99;
         foreach (l_wb[i]) l_wb[i] = -99;
         foreach (faw[i]) faw[i] = -99;
      end else begin
         t = t + 1;
         c = crc_dm_en ? 5 : 0;
         k = {cmd_bg, cmd_ba};
         fw = (page_size == PAGE_2K) ? 28 : (page_size == PAGE_1K) ? 20 : 16;
         if (cmd_valid && (cmd_code == CMD_RD || cmd_code == CMD_WR)) begin
            foreach (l_col[g]) if (t - l_col[g] < 4) viol++;
            l_col[cmd_bg] = t;
         end
         if (cmd_valid && cmd_code == CMD_RD) begin
            foreach (l_wr[g])
               if (t - l_wr[g] < ((g == cmd_bg) ? 4 : 2) + c) viol++;
            l_rd[k] = t;
         end
         if (cmd_valid && cmd_code == CMD_WR) begin
            l_wr[cmd_bg] = t;
            l_wb[k] = t;
         end
         if (cmd_valid && cmd_code == CMD_ACT) begin
            foreach (l_act[g]) if (t - l_act[g] < 4) viol++;
            if (t - faw[fp] < fw) viol++;
            faw[fp] = t;
            fp = (fp + 1) % 4;
            l_act[cmd_bg] = t;
         end
         if (cmd_valid && cmd_code == CMD_PRE) begin
            if (t - l_rd[k] < 4) viol++;
            if (t - l_wb[k] < 1 + c) viol++;
         end
         if (cmd_valid && cmd_code == CMD_MRS) begin
            if (t - l_mrs < 8) viol++;
            l_mrs = t;
         end
      end
   end
endmodule
`default_nettype wire

// ### bench/ddc_cmd_spacer_bench.sv
// self-checking bench for the command spacing controller
`timescale 1ns/10ps
`default_nettype none
module ddc_cmd_spacer_bench
   import ddc_pkg::*;
;
   logic            clk, rst_n, crc, req_valid, req_ack, cmd_valid;
   logic [1:0]      page;
   logic [2:0]      req_cmd, cmd_code;
   logic [BG_W-1:0] req_bg, cmd_bg;
   logic [BA_W-1:0] req_ba, cmd_ba;
   int              viol, errors, n_checks, cyc, t1, t2, r;
   ddc_cmd_type     cl [5] = '{CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_MRS};

   ddc_cmd_spacer dut (.CORE_CLK(clk), .RST_N(rst_n), .PAGE_SIZE(page),
      .CRC_DM_EN(crc), .REQ_VALID(req_valid), .REQ_CMD(req_cmd),
      .REQ_BG(req_bg), .REQ_BA(req_ba), .REQ_ACK(req_ack),
      .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code), .CMD_BG(cmd_bg),
      .CMD_BA(cmd_ba));
   ddc_mem_model mem (.clk(clk), .rst_n(rst_n), .page_size(page),
      .crc_dm_en(crc), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_bg(cmd_bg), .cmd_ba(cmd_ba), .viol(viol));

   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check_cmd(input logic [6:0] exp, input logic [6:0] got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH command exp %h got %h", exp, got);
      end
   endtask
   task automatic check_gap(input int exp, input int got);
      n_checks++;
      if (got != exp) begin
         errors++;
         $display("MISMATCH cycles exp %0d got %0d", exp, got);
      end
   endtask
   // keeps the request up across the ack edge so back-to-back gaps stay exact
   task automatic send(input logic [2:0] c, input logic [1:0] g,
                       input logic [1:0] b, output int at);
      int n;
      req_valid <= 1'h1;
      req_cmd <= c;
      req_bg <= g;
      req_ba <= b;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (req_ack !== 1'h1 && n < 300);
      at = cyc;
      check_cmd({c, g, b}, {cmd_code, cmd_bg, cmd_ba});
      @(posedge clk);
   endtask
   task automatic idle(input int n);
      req_valid <= 1'h0;
      repeat (n) @(posedge clk);
   endtask
   task automatic pair(input logic [2:0] c1, input logic [1:0] g1, b1,
                       input logic [2:0] c2, input logic [1:0] g2, b2,
                       input int exp);
      idle(40);
      send(c1, g1, b1, t1);
      send(c2, g2, b2, t2);
      check_gap(exp, t2 - t1);
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      $display("MISMATCH watchdog exp done got hang");
      test_done;
   end

   initial begin
      rst_n = 1'h0;
      page = PAGE_2K;
      crc = 1'h0;
      req_valid = 1'h0;
      req_cmd = 3'h0;
      req_bg = 2'h0;
      req_ba = 2'h0;
      r = $urandom(3);
      repeat (10) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      pair(CMD_RD, 0, 1, CMD_RD, 0, 2, 4);
      pair(CMD_WR, 0, 1, CMD_RD, 1, 0, 4);
      pair(CMD_ACT, 1, 0, CMD_ACT, 2, 0, 4);
      pair(CMD_ACT, 1, 1, CMD_ACT, 1, 2, 4);
      pair(CMD_WR, 2, 0, CMD_RD, 2, 1, 4);
      pair(CMD_RD, 0, 1, CMD_PRE, 0, 1, 4);
      pair(CMD_WR, 3, 1, CMD_PRE, 3, 1, 2);
      pair(CMD_MRS, 0, 0, CMD_MRS, 0, 0, 8);
      crc <= 1'h1;
      pair(CMD_WR, 2, 0, CMD_RD, 2, 1, 9);
      pair(CMD_WR, 0, 1, CMD_RD, 1, 0, 7);
      pair(CMD_WR, 3, 1, CMD_PRE, 3, 1, 6);
      $display("test pairs done");
      for (int p = 0; p < 3; p++) begin
         page <= 2'(p);
         idle(40);
         send(CMD_ACT, 0, 0, t1);
         for (int g = 1; g < 5; g++) send(CMD_ACT, 2'(g), 2'(g / 4), t2);
         check_gap((p == 2) ? 28 : (p == 1) ? 20 : 16, t2 - t1);
      end
      $display("test window done");
      for (int i = 0; i < 240; i++) begin
         if (i % 60 == 0) begin
            idle(40);
            page <= 2'($urandom);
            crc <= 1'($urandom);
         end
         send(cl[$urandom % 5], 2'($urandom), 2'($urandom), t1);
      end
      idle(40);
      check_gap(0, viol);
      $display("test random done");
      test_done;
   end
endmodule

bind ddc_cmd_spacer ddc_cmd_spacer_properties #(
   .WRITE_START_CYC(WRITE_START_CYC)
) u_props (
   .CORE_CLK  (CORE_CLK),
   .RST_N     (RST_N),
   .PAGE_SIZE (PAGE_SIZE),
   .CRC_DM_EN (CRC_DM_EN),
   .REQ_VALID (REQ_VALID),
   .REQ_CMD   (REQ_CMD),
   .REQ_BG    (REQ_BG),
   .REQ_BA    (REQ_BA),
   .REQ_ACK   (REQ_ACK),
   .CMD_VALID (CMD_VALID),
   .CMD_CODE  (CMD_CODE),
   .CMD_BG    (CMD_BG),
   .CMD_BA    (CMD_BA)
);
`default_nettype wire
